// ---- tra_alu.sv ----
`timescale 1ns/1ps

// Functional notes
// - operand select holds two 4-bit nibbles: channel bit plus hit number
// - channel bit zero picks channel one, one picks channel two
// - every calculation starts with lower operand minus upper operand
// - upper nibble zero gives absolute start-to-stop interval of lower hit
// - calibrate bit in control 0 calibrates the difference before storing
// - multiply bit scales the result by the 24-bit scale factor
// - scale factor is three writable byte registers low, mid, high
// - scale msb weighs one; high byte resets to 128, factor one
// - both bits clear stores the raw difference only
// - range 1 calibrate: subtract offset, divide by gradient
// - multiply also set scales the calibrated quotient
// - range 2 adds coarse count to calibrated fine difference
// - overflow sets result bit of weight 128
// - range 2 computes intervals between any two selected hits, not only from start
// - range 2 fine count placement differs in normal and high resolution
// - range 2 coarse address derived from the two fine count numbers
// - nonsense fine count picks are computed and stored silently
// - operands come from raw store, result goes to result register
// - cal values are one and two calibration periods from a cal run
module tra_alu (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // microcontroller port
    input  wire logic [3:0]  up_addr,
    input  wire logic        up_ale,
    input  wire logic        up_cs_n,
    input  wire logic        up_wr_n,
    input  wire logic        up_rd_n,
    input  wire logic [7:0]  up_data_in,
    output logic      [7:0]  up_data_out,
    output logic             up_data_oe,
    // measuring core
    input  wire logic        range2_mode,
    input  wire logic        high_res_mode,
    input  wire logic        raw_wr_en,
    input  wire logic [4:0]  raw_wr_addr,
    input  wire logic [15:0] raw_wr_data,
    input  wire logic        calc_start,
    // result and status
    output logic             calc_busy,
    output logic             calc_done,
    output logic      [31:0] first_result_register
);

    // ****************************************************************
    // register port
    // ****************************************************************
    logic [3:0]  alat_ff, nxt_alat;
    logic        wrn_ff,  nxt_wrn;
    logic [7:0]  ctrl0_ff, nxt_ctrl0;
    logic [7:0]  opsel_ff, nxt_opsel;
    logic [7:0]  sclo_ff, nxt_sclo;
    logic [7:0]  scmi_ff, nxt_scmi;
    logic [7:0]  schi_ff, nxt_schi;
    logic [7:0]  rdat_ff, nxt_rdat;
    logic [3:0]  eff_addr;
    logic        wr_stb;

    logic [tra_pkg::RES_W-1:0] result_ff;
    logic                      ovf_ff;
    tra_pkg::tra_state_t       state_ff;

    // ale high makes the latch transparent
    assign eff_addr   = up_ale ? up_addr : alat_ff;
    // data is taken on the rising wr_n edge, as on a real bus
    assign wr_stb     = up_wr_n & ~wrn_ff & ~up_cs_n;
    assign up_data_oe = ~up_cs_n & ~up_rd_n;
    assign up_data_out = rdat_ff;

    // register writes and read mux
    always_comb begin
        nxt_alat  = up_ale ? up_addr : alat_ff;
        nxt_wrn   = up_wr_n;
        nxt_ctrl0 = ctrl0_ff;
        nxt_opsel = opsel_ff;
        nxt_sclo  = sclo_ff;
        nxt_scmi  = scmi_ff;
        nxt_schi  = schi_ff;
        if (wr_stb) begin
            case (eff_addr)
                tra_pkg::CTRL0_ADDR:      nxt_ctrl0 = up_data_in;
                tra_pkg::OPSEL_ADDR:      nxt_opsel = up_data_in;
                tra_pkg::SCALE_LOW_ADDR:  nxt_sclo  = up_data_in;
                tra_pkg::SCALE_MID_ADDR:  nxt_scmi  = up_data_in;
                tra_pkg::SCALE_HIGH_ADDR: nxt_schi  = up_data_in;
                default:                  nxt_ctrl0 = ctrl0_ff;
            endcase
        end
        case (eff_addr)
            tra_pkg::RES_B0_ADDR: nxt_rdat = result_ff[7:0];
            tra_pkg::RES_B1_ADDR: nxt_rdat = result_ff[15:8];
            tra_pkg::RES_B2_ADDR: nxt_rdat = result_ff[23:16];
            tra_pkg::RES_B3_ADDR: nxt_rdat = result_ff[31:24];
            tra_pkg::STATUS_ADDR:
                nxt_rdat = {6'h00, ovf_ff, (state_ff != tra_pkg::ST_IDLE)};
            default:              nxt_rdat = 8'h00;
        endcase
    end

    // port registers; scale high byte comes up as factor one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alat_ff  <= 4'h0;
            wrn_ff   <= 1'b1;
            ctrl0_ff <= tra_pkg::CTRL0_RST;
            opsel_ff <= tra_pkg::OPSEL_RST;
            sclo_ff  <= tra_pkg::SCALE_LOW_RST;
            scmi_ff  <= tra_pkg::SCALE_MID_RST;
            schi_ff  <= tra_pkg::SCALE_HIGH_RST;
            rdat_ff  <= 8'h00;
        end else begin
            alat_ff  <= nxt_alat;
            wrn_ff   <= nxt_wrn;
            ctrl0_ff <= nxt_ctrl0;
            opsel_ff <= nxt_opsel;
            sclo_ff  <= nxt_sclo;
            scmi_ff  <= nxt_scmi;
            schi_ff  <= nxt_schi;
            rdat_ff  <= nxt_rdat;
        end
    end

    // ****************************************************************
    // operand addressing
    // ****************************************************************
    logic [4:0]  ram_rd_addr;
    logic [15:0] ram_rd_data;
    logic [2:0]  ld_cnt_ff, nxt_ld_cnt;

    // bank 0 address of a selector; range 2 maps fine counts
    function automatic logic [4:0] sel_addr(input logic [3:0] sel,
                                             input logic       r2,
                                             input logic       hr);
        logic [2:0] hit;
        hit = sel[2:0];
        if (r2 && hit < tra_pkg::HIT_ONE_PERIOD_CAL_VALUE) begin
            if (hr) begin
                sel_addr = {2'b01, hit};
            end else if (hit == tra_pkg::FC_CH2_NORMAL) begin
                sel_addr = {2'b01, 3'h1};
            end else begin
                sel_addr = {2'b00, hit};
            end
        end else begin
            sel_addr = {1'b0, sel[3], hit};
        end
    endfunction : sel_addr

    // read slots: lower, upper, one_period_cal_value, two_period_cal_value, coarse
    always_comb begin
        case (ld_cnt_ff)
            3'h0: ram_rd_addr = sel_addr(opsel_ff[3:0], range2_mode,
                                         high_res_mode);
            3'h1: ram_rd_addr = sel_addr(opsel_ff[7:4], range2_mode,
                                         high_res_mode);
            3'h2: ram_rd_addr = {1'b0, opsel_ff[3], tra_pkg::HIT_ONE_PERIOD_CAL_VALUE};
            3'h3: ram_rd_addr = {1'b0, opsel_ff[3], tra_pkg::HIT_TWO_PERIOD_CAL_VALUE};
            // coarse hit index from the fine count numbers
            3'h4: ram_rd_addr = {2'b10, opsel_ff[6:4] - opsel_ff[2:0]};
            default: ram_rd_addr = 5'h00;
        endcase
    end

    tra_ram u_raw (
        .clk     (clk),
        .wr_en   (raw_wr_en),
        .wr_addr (raw_wr_addr),
        .wr_data (raw_wr_data),
        .rd_addr (ram_rd_addr),
        .rd_data (ram_rd_data)
    );

    // ****************************************************************
    // sequential arithmetic
    // ****************************************************************
    tra_pkg::tra_state_t nxt_state;
    logic [15:0] a_ff, nxt_a, b_ff, nxt_b;
    logic [15:0] c1_ff, nxt_c1, c2_ff, nxt_c2, cc_ff, nxt_cc;
    logic        cal_en_ff, nxt_cal_en, mul_en_ff, nxt_mul_en;
    logic        neg_ff, nxt_neg, nxt_ovf, done_ff, nxt_done;
    logic [5:0]  cnt_ff, nxt_cnt;
    logic [15:0] den_ff, nxt_den, rem_ff, nxt_rem;
    logic [tra_pkg::DIV_W-1:0] nq_ff, nxt_nq;
    logic [31:0] val_ff, nxt_val, nxt_result;
    logic [55:0] acc_ff, nxt_acc, mcand_ff, nxt_mcand;
    logic [23:0] mplier_ff, nxt_mplier;
    logic [17:0] diff;
    logic [19:0] nume, nmag;
    logic [16:0] grad, trial;
    logic [32:0] sum;
    logic [31:0] qv, pv;

    // stages strictly in order, result written only in ST_DONE
    always_comb begin
        nxt_state  = state_ff;
        nxt_ld_cnt = ld_cnt_ff;
        nxt_a = a_ff;  nxt_b = b_ff;  nxt_cc = cc_ff;
        nxt_c1 = c1_ff;  nxt_c2 = c2_ff;
        nxt_cal_en = cal_en_ff;  nxt_mul_en = mul_en_ff;
        nxt_neg = neg_ff;  nxt_ovf = ovf_ff;  nxt_done = 1'b0;
        nxt_cnt = cnt_ff;  nxt_den = den_ff;  nxt_rem = rem_ff;
        nxt_nq = nq_ff;  nxt_val = val_ff;  nxt_result = result_ff;
        nxt_acc = acc_ff;  nxt_mcand = mcand_ff;  nxt_mplier = mplier_ff;
        // lower minus upper, both zero-extended raw values
        diff  = {2'b00, a_ff} - {2'b00, b_ff};
        grad  = {1'b0, c2_ff} - {1'b0, c1_ff};
        // range 1 removes the offset 2*one_period_cal_value - two_period_cal_value first
        nume  = range2_mode ? {{2{diff[17]}}, diff}
              : {{2{diff[17]}}, diff} - ({3'b000, c1_ff, 1'b0}
              - {4'h0, c2_ff});
        nmag  = nume[19] ? 20'h00000 - nume : nume;
        trial = {rem_ff, nq_ff[tra_pkg::DIV_W-1]};
        qv    = neg_ff ? 32'h00000000 - nq_ff[31:0] : nq_ff[31:0];
        sum   = {qv[31], qv} + {1'b0, cc_ff[7:0], 24'h000000};
        pv    = acc_ff[54:23];
        case (state_ff)
            tra_pkg::ST_IDLE: begin
                if (calc_start) begin
                    nxt_ld_cnt = 3'h0;
                    nxt_ovf    = 1'b0;
                    nxt_cal_en = ctrl0_ff[tra_pkg::CTRL0_CAL_BIT];
                    nxt_mul_en = ctrl0_ff[tra_pkg::CTRL0_SCALE_FACTOR_BIT];
                    nxt_state  = tra_pkg::ST_LOAD;
                end
            end
            tra_pkg::ST_LOAD: begin
                // read data lags the address by one cycle
                case (ld_cnt_ff)
                    3'h1: nxt_a = ram_rd_data;
                    // zero upper nibble means measure from start
                    3'h2: nxt_b = (opsel_ff[7:4] == 4'h0) ? 16'h0000
                                : ram_rd_data;
                    3'h3: nxt_c1 = ram_rd_data;
                    3'h4: nxt_c2 = ram_rd_data;
                    3'h5: nxt_cc = ram_rd_data;
                    default: nxt_a = a_ff;
                endcase
                nxt_ld_cnt = ld_cnt_ff + 3'h1;
                if (ld_cnt_ff == tra_pkg::LOAD_LAST) begin
                    nxt_state = tra_pkg::ST_CALC;
                end
            end
            tra_pkg::ST_CALC: begin
                if (!cal_en_ff) begin
                    // raw difference, no correction
                    nxt_val   = {{14{diff[17]}}, diff};
                    nxt_state = mul_en_ff ? tra_pkg::ST_MSET
                              : tra_pkg::ST_DONE;
                end else if (grad[16] || grad == 17'h00000) begin
                    // zero or negative gradient cannot divide
                    nxt_ovf   = 1'b1;
                    nxt_val   = 32'h00000000;
                    nxt_state = tra_pkg::ST_DONE;
                end else begin
                    nxt_neg   = nume[19];
                    nxt_nq    = {nmag, 24'h000000};
                    nxt_rem   = 16'h0000;
                    nxt_den   = grad[15:0];
                    nxt_cnt   = tra_pkg::DIV_STEPS;
                    nxt_state = tra_pkg::ST_DIV;
                end
            end
            tra_pkg::ST_DIV: begin
                // one restoring step per cycle, msb first
                if (trial >= {1'b0, den_ff}) begin
                    nxt_rem = 16'(trial - {1'b0, den_ff});
                    nxt_nq  = {nq_ff[tra_pkg::DIV_W-2:0], 1'b1};
                end else begin
                    nxt_rem = trial[15:0];
                    nxt_nq  = {nq_ff[tra_pkg::DIV_W-2:0], 1'b0};
                end
                nxt_cnt = cnt_ff - 6'h01;
                if (cnt_ff == 6'h01) begin
                    nxt_state = tra_pkg::ST_FIX;
                end
            end
            tra_pkg::ST_FIX: begin
                // quotient above bit 30 is out of range
                if (|nq_ff[tra_pkg::DIV_W-1:31]) begin
                    nxt_ovf = 1'b1;
                end
                if (range2_mode) begin
                    // coarse periods on top of the fine fraction
                    nxt_val = sum[31:0];
                    if ((|cc_ff[15:8]) || (sum[32] != sum[31])) begin
                        nxt_ovf = 1'b1;
                    end
                end else begin
                    nxt_val = qv;
                end
                nxt_state = mul_en_ff ? tra_pkg::ST_MSET
                          : tra_pkg::ST_DONE;
            end
            tra_pkg::ST_MSET: begin
                nxt_neg    = val_ff[31];
                nxt_mcand  = {24'h000000,
                              val_ff[31] ? 32'h00000000 - val_ff : val_ff};
                nxt_mplier = {schi_ff, scmi_ff, sclo_ff};
                nxt_acc    = 56'h00000000000000;
                nxt_cnt    = tra_pkg::MUL_STEPS;
                nxt_state  = tra_pkg::ST_MUL;
            end
            tra_pkg::ST_MUL: begin
                // shift-add, one multiplier bit per cycle
                if (mplier_ff[0]) begin
                    nxt_acc = acc_ff + mcand_ff;
                end
                nxt_mcand  = {mcand_ff[54:0], 1'b0};
                nxt_mplier = {1'b0, mplier_ff[23:1]};
                nxt_cnt    = cnt_ff - 6'h01;
                if (cnt_ff == 6'h01) begin
                    nxt_state = tra_pkg::ST_DONE;
                end
            end
            tra_pkg::ST_DONE: begin
                // scale msb weighs one, so drop 23 fraction bits
                if (mul_en_ff) begin
                    nxt_result = neg_ff ? 32'h00000000 - pv : pv;
                    if (|acc_ff[55:54]) begin
                        nxt_result[31] = 1'b1;
                        nxt_ovf        = 1'b1;
                    end
                end else begin
                    nxt_result = val_ff;
                end
                // overflow marks bit 31, weight 128 in 8.24 format
                if (ovf_ff) begin
                    nxt_result[31] = 1'b1;
                end
                nxt_done  = 1'b1;
                nxt_state = tra_pkg::ST_IDLE;
            end
            default: nxt_state = tra_pkg::ST_IDLE;
        endcase
    end

    // sequencer and datapath registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= tra_pkg::ST_IDLE;
            ld_cnt_ff <= 3'h0;
            a_ff <= 16'h0000;  b_ff <= 16'h0000;  cc_ff <= 16'h0000;
            c1_ff <= 16'h0000;  c2_ff <= 16'h0000;
            cal_en_ff <= 1'b0;  mul_en_ff <= 1'b0;
            neg_ff <= 1'b0;  ovf_ff <= 1'b0;  done_ff <= 1'b0;
            cnt_ff <= 6'h00;  den_ff <= 16'h0000;  rem_ff <= 16'h0000;
            nq_ff  <= 44'h00000000000;
            val_ff <= 32'h00000000;
            result_ff <= 32'h00000000;
            acc_ff <= 56'h00000000000000;
            mcand_ff <= 56'h00000000000000;
            mplier_ff <= 24'h000000;
        end else begin
            state_ff  <= nxt_state;
            ld_cnt_ff <= nxt_ld_cnt;
            a_ff <= nxt_a;  b_ff <= nxt_b;  cc_ff <= nxt_cc;
            c1_ff <= nxt_c1;  c2_ff <= nxt_c2;
            cal_en_ff <= nxt_cal_en;  mul_en_ff <= nxt_mul_en;
            neg_ff <= nxt_neg;  ovf_ff <= nxt_ovf;  done_ff <= nxt_done;
            cnt_ff <= nxt_cnt;  den_ff <= nxt_den;  rem_ff <= nxt_rem;
            nq_ff  <= nxt_nq;
            val_ff <= nxt_val;
            result_ff <= nxt_result;
            acc_ff <= nxt_acc;
            mcand_ff <= nxt_mcand;
            mplier_ff <= nxt_mplier;
        end
    end

    // nonsense selections run through unchecked
    assign calc_busy = (state_ff != tra_pkg::ST_IDLE);
    assign calc_done = done_ff;
    assign first_result_register = result_ff;

endmodule : tra_alu

// ---- tra_alu_asserts.sv ----
`timescale 1ns/1ps

// ****************************************
// port checks of the result alu
// ****************************************
module tra_alu_asserts (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [3:0]  up_addr,
    input wire logic        up_ale,
    input wire logic        up_cs_n,
    input wire logic        up_rd_n,
    input wire logic [7:0]  up_data_out,
    input wire logic        up_data_oe,
    // calculation
    input wire logic        calc_start,
    input wire logic        calc_busy,
    input wire logic        calc_done,
    input wire logic [31:0] first_result_register
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // bus drive is a pure decode, so no stale enable after a read
    AST_OE: assert property (up_data_oe == (!up_cs_n && !up_rd_n))
        else $error("read enable differs from select and strobe");
    // sequencer life cycle
    AST_BUSY_START: assert property (
        calc_start && !calc_busy && !calc_done |=> calc_busy)
        else $error("start while idle did not raise busy");
    AST_DONE_PULSE: assert property (calc_done |=> !calc_done)
        else $error("done longer than one cycle");
    AST_HOLD: assert property (
        !calc_done |-> $stable(first_result_register))
        else $error("result changed without done");
    AST_MIN_LAT: assert property ($rose(calc_busy) |-> !calc_done [*6])
        else $error("done before the load stage ended");
    AST_BOUND: assert property (
        $rose(calc_busy) |-> ##[1:80] calc_done)
        else $error("calculation never completed");
    AST_IDLE_AFTER: assert property (
        calc_done && !calc_start |=> !calc_busy)
        else $error("busy after done");
    // read side: unmapped gives zero, byte zero mirrors the result
    AST_UNMAPPED: assert property (
        up_ale && up_addr > 4'h4 |=> up_data_out == 8'h00)
        else $error("unmapped read not zero");
    AST_BYTE0: assert property (
        up_ale && up_addr == tra_pkg::RES_B0_ADDR
        |=> up_data_out == $past(first_result_register[7:0]))
        else $error("result byte zero read wrong");
endmodule : tra_alu_asserts

bind tra_alu tra_alu_asserts u_chk (.clk(clk), .rst_n(rst_n),
    .up_addr(up_addr), .up_ale(up_ale), .up_cs_n(up_cs_n),
    .up_rd_n(up_rd_n), .up_data_out(up_data_out), .up_data_oe(up_data_oe),
    .calc_start(calc_start), .calc_busy(calc_busy), .calc_done(calc_done),
    .first_result_register(first_result_register));

// ---- tra_alu_tb_top.sv ----
`timescale 1ns/1ps

// ****************************************
// bench for the result alu
// ****************************************
module tra_alu_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  up_addr = 4'h0;
    logic        up_cs_n = 1'b1;
    logic        up_wr_n = 1'b1;
    logic        up_rd_n = 1'b1;
    logic [7:0]  up_data_in = 8'h00;
    logic [7:0]  up_data_out;
    logic        range2_mode = 1'b0;
    logic        high_res_mode = 1'b0;
    logic        raw_wr_en = 1'b0;
    logic [4:0]  raw_wr_addr = 5'h00;
    logic [15:0] raw_wr_data = 16'h0000;
    logic        calc_start = 1'b0;
    logic        calc_busy;
    logic        calc_done;
    logic [31:0] res;
    logic [7:0]  d8;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [7:0]  ops [8] = '{8'ha4, 8'h13, 8'h3b, 8'h04, 8'h0c, 8'h67,
                             8'h0f, 8'hc1};

    always #5 clk = ~clk;

    // separate address bus, so the latch stays transparent
    tra_alu uut (.clk(clk), .rst_n(rst_n), .up_addr(up_addr), .up_ale(1'b1),
        .up_cs_n(up_cs_n), .up_wr_n(up_wr_n), .up_rd_n(up_rd_n),
        .up_data_in(up_data_in), .up_data_out(up_data_out), .up_data_oe(),
        .range2_mode(range2_mode), .high_res_mode(high_res_mode),
        .raw_wr_en(raw_wr_en), .raw_wr_addr(raw_wr_addr),
        .raw_wr_data(raw_wr_data), .calc_start(calc_start),
        .calc_busy(calc_busy), .calc_done(calc_done),
        .first_result_register(res));

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // raw value of {chan,hit}; channels get different spacing
    function automatic logic [15:0] rv(input logic [3:0] s);
        return 16'h1000 + 16'(s[2:0]) * (s[3] ? 16'h0300 : 16'h0200);
    endfunction : rv

    function automatic logic [31:0] dif(input logic [7:0] op);
        return 32'(rv(op[3:0])) - (op[7:4] == 4'h0 ? 32'h0 : 32'(rv(op[7:4])));
    endfunction : dif

    // write completes on the rising strobe; data held across it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {up_addr, up_data_in, up_cs_n, up_wr_n} = {a, d, 2'b00};
        @(posedge clk);
        #1 up_wr_n = 1'b1;
        @(posedge clk);
        #1 up_cs_n = 1'b1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 {up_addr, up_cs_n, up_rd_n} = {a, 2'b00};
        repeat (2) @(posedge clk);
        #1 d = up_data_out;
        {up_cs_n, up_rd_n} = 2'b11;
    endtask : rd

    task automatic rw(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 {raw_wr_en, raw_wr_addr, raw_wr_data} = {1'b1, a, d};
        @(posedge clk);
        #1 raw_wr_en = 1'b0;
    endtask : rw

    // one calculation; a second start mid-run must be ignored
    task automatic calc(input string nm, input logic [7:0] ctl, op,
                        input int lat, input logic [31:0] e, m);
        int          n;
        logic [31:0] b;
        logic [7:0]  d;
        wr(tra_pkg::CTRL0_ADDR, ctl);
        wr(tra_pkg::OPSEL_ADDR, op);
        @(posedge clk);
        #1 calc_start = 1'b1;
        // the start edge itself counts as cycle zero
        n = -1;
        do begin
            @(posedge clk);
            #1 n++;
            calc_start = (n == 3);
        end while (calc_done !== 1'b1 && n < 200);
        chk({nm, " cycles"}, 32'(lat), 32'(n));
        chk(nm, e, res & m);
        for (int i = 0; i < 4; i++) begin
            rd(4'(i), d);
            b[8*i +: 8] = d;
        end
        chk({nm, " bus"}, e, b & m);
        $display("test %s done", nm);
    endtask : calc

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int c = 0; c < 2; c++) begin
            for (int h = 1; h < 8; h++) begin
                rw({1'b0, c[0], h[2:0]}, rv({c[0], h[2:0]}));
            end
        end
        rw(5'h13, 16'h000a);
        rw(5'h14, 16'h000a);
        foreach (ops[i]) begin
            calc("raw", 8'h00, ops[i], 8,
                 dif(ops[i]), '1);
        end
        calc("one_period_cal_value", 8'h40, 8'h06, 53, 32'h0100_0000, '1);
        calc("two_period_cal_value", 8'h40, 8'h07, 53, 32'h0200_0000, '1);
        calc("scl_rst", 8'h60, 8'h07, 78, 32'h0200_0000, '1);
        wr(tra_pkg::SCALE_LOW_ADDR, 8'h01);
        wr(tra_pkg::SCALE_MID_ADDR, 8'h01);
        calc("scl", 8'h60, 8'h06, 78, 32'h0100_0202, '1);
        wr(tra_pkg::SCALE_LOW_ADDR, 8'h00);
        wr(tra_pkg::SCALE_MID_ADDR, 8'h00);
        wr(tra_pkg::SCALE_HIGH_ADDR, 8'hc0);
        // uncalibrated operands kept well below the multiply limit
        calc("scale_factor", 8'h20, 8'h04, 33, 32'h0000_2400, '1);
        calc("scale_factor_neg", 8'h20, 8'hc1, 33, 32'hffff_f100, '1);
        range2_mode = 1'b1;
        calc("r2", 8'h40, 8'h41, 53, 32'h0700_0000, '1);
        calc("r2_fc5", 8'h40, 8'h51, 53, 32'h0980_0000, '1);
        high_res_mode = 1'b1;
        calc("r2_hr", 8'h40, 8'h41, 53, 32'h0580_0000, '1);
        {range2_mode, high_res_mode} = 2'b00;
        rw(5'h0f, 16'h2200);
        // zero gradient aborts straight after the subtract stage
        calc("ovf", 8'h40, 8'h0c, 8, 32'h8000_0000, 32'h8000_0000);
        rd(tra_pkg::STATUS_ADDR, d8);
        chk("status", 32'h2, {24'h0, d8});
        rd(4'h5, d8);
        chk("unmapped", 32'h0, {24'h0, d8});
        $display("test regs done");
        results();
    end
endmodule : tra_alu_tb_top

// ---- tra_pkg.sv ----
package tra_pkg;

    // ****************************************************************
    // register port map
    // ****************************************************************
    localparam logic [3:0] CTRL0_ADDR      = 4'h0;
    localparam logic [3:0] OPSEL_ADDR      = 4'h2;
    localparam logic [3:0] SCALE_LOW_ADDR  = 4'h7;
    localparam logic [3:0] SCALE_MID_ADDR  = 4'h8;
    localparam logic [3:0] SCALE_HIGH_ADDR = 4'h9;
    // read side: result bytes then status
    localparam logic [3:0] RES_B0_ADDR     = 4'h0;
    localparam logic [3:0] RES_B1_ADDR     = 4'h1;
    localparam logic [3:0] RES_B2_ADDR     = 4'h2;
    localparam logic [3:0] RES_B3_ADDR     = 4'h3;
    localparam logic [3:0] STATUS_ADDR     = 4'h4;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int         CTRL0_SCALE_FACTOR_BIT  = 5;
    localparam int         CTRL0_CAL_BIT   = 6;
    localparam logic [7:0] CTRL0_RST       = 8'h00;
    localparam logic [7:0] OPSEL_RST       = 8'h55;
    localparam logic [7:0] SCALE_LOW_RST   = 8'h00;
    localparam logic [7:0] SCALE_MID_RST   = 8'h00;
    localparam logic [7:0] SCALE_HIGH_RST  = 8'h80;
    localparam logic [2:0] HIT_ONE_PERIOD_CAL_VALUE        = 3'h6;
    localparam logic [2:0] HIT_TWO_PERIOD_CAL_VALUE        = 3'h7;
    localparam logic [2:0] FC_CH2_NORMAL   = 3'h5;

    // ****************************************************************
    // datapath sizes and cycle counts
    // ****************************************************************
    localparam int         RAW_W           = 16;
    localparam int         RES_W           = 32;
    localparam int         FRAC_W          = 24;
    localparam int         SCALE_W         = 24;
    localparam int         SCALE_FRAC      = 23;
    localparam int         DIV_W           = 44;
    localparam logic [5:0] DIV_STEPS       = 6'h2c;
    localparam logic [5:0] MUL_STEPS       = 6'h18;
    localparam logic [2:0] LOAD_LAST       = 3'h5;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_LOAD = 8'h02,
        ST_CALC = 8'h04,
        ST_DIV  = 8'h08,
        ST_FIX  = 8'h10,
        ST_MSET = 8'h20,
        ST_MUL  = 8'h40,
        ST_DONE = 8'h80
    } tra_state_t;

endpackage : tra_pkg

// ---- tra_ram.sv ----
`timescale 1ns/1ps

// raw value store: bank 0 {chan,hit}, bank 1 coarse counts
module tra_ram (
    // clock
    input  wire logic                     clk,
    // write side from the measuring core
    input  wire logic                     wr_en,
    input  wire logic [4:0]               wr_addr,
    input  wire logic [tra_pkg::RAW_W-1:0] wr_data,
    // registered read side
    input  wire logic [4:0]               rd_addr,
    output logic      [tra_pkg::RAW_W-1:0] rd_data
);

    logic [tra_pkg::RAW_W-1:0] mem [0:31];

    // no reset on the array; contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : tra_ram
